// >>> core/smm_io_break_decoder.sv
// management-mode i/o break decoder with indexed configuration port
`timescale 1ns/1ps
module smm_io_break_decoder
  import io_break_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  input  wire io_break_pkg::io_addr_t io_addr,
  input  wire logic                   io_rd,
  input  wire logic                   io_wr,
  input  wire io_break_pkg::byte_t    io_wdata,
  input  wire logic                   mgmt_enable,
  input  wire logic                   mgmt_write_lock,
  input  wire logic                   mgmt_active,
  input  wire logic                   short_decode_sel,
  input  wire logic [4:0]             timer_flags,
  output logic [7:0]                  io_rdata,
  output logic                        io_rdata_valid,
  output logic                        mgmt_irq_n,
  output logic                        any_trap_pending
);

  // ==========================================================
  // state
  byte_t index_reg;
  byte_t mask_a_reg;
  byte_t mask_b_reg;
  byte_t status_a_reg;
  byte_t status_b_reg;
  byte_t win2_high_reg;
  byte_t win2_low_reg;
  byte_t win1_high_reg;
  byte_t win1_low_reg;
  byte_t rdata_reg;
  logic  rdata_valid_reg;
  logic  irq_n_reg;
  logic  pending_reg;

  // ==========================================================
  // decode helpers
  function automatic logic in_range(input io_addr_t a,
                                    input io_addr_t lo,
                                    input io_addr_t hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic is_reg(input byte_t idx, input byte_t off);
    return idx == off;
  endfunction

  // ==========================================================
  // address view and cycle qualifiers
  wire io_addr_t eff_addr;
  wire logic     io_cycle;
  wire logic     index_wr;
  wire logic     data_wr;
  wire logic     data_rd;
  wire logic     write_ok;

  // short decode folds the 64k space onto the low 1k
  assign eff_addr = short_decode_sel ? {6'h00, io_addr[9:0]}
                                     : io_addr; // see [RULE_25]
  assign io_cycle = io_rd | io_wr;
  assign index_wr = io_wr && (io_addr == CFG_INDEX_PORT);
  assign data_wr  = io_wr && (io_addr == CFG_DATA_PORT);
  assign data_rd  = io_rd && (io_addr == CFG_DATA_PORT);
  // lock only bites while the handler is not running
  assign write_ok = mgmt_active || !mgmt_write_lock; // see [RULE_24]

  wire logic wr_mask_a;
  wire logic wr_mask_b;
  wire logic wr_win2_high;
  wire logic wr_win2_low;
  wire logic wr_win1_high;
  wire logic wr_win1_low;
  wire logic rd_status_a;
  wire logic rd_status_b;
  wire logic rd_mapped;

  assign wr_mask_a    = data_wr && write_ok && is_reg(index_reg, OFF_MASK_A);
  assign wr_mask_b    = data_wr && write_ok && is_reg(index_reg, OFF_MASK_B);
  assign wr_win2_high = data_wr && write_ok
                        && is_reg(index_reg, OFF_WIN2_HIGH);
  assign wr_win2_low  = data_wr && write_ok
                        && is_reg(index_reg, OFF_WIN2_LOW);
  assign wr_win1_high = data_wr && write_ok
                        && is_reg(index_reg, OFF_WIN1_HIGH);
  assign wr_win1_low  = data_wr && write_ok
                        && is_reg(index_reg, OFF_WIN1_LOW);
  assign rd_status_a  = data_rd && is_reg(index_reg, OFF_STATUS_A);
  assign rd_status_b  = data_rd && is_reg(index_reg, OFF_STATUS_B);
  assign rd_mapped    = data_rd && (index_reg >= OFF_MASK_A)
                        && (index_reg <= OFF_WIN1_LOW);

  // ==========================================================
  // programmable windows
  logic win1_hit;
  logic win2_hit;

  io_window_match u_win1 (
    .addr             (io_addr),
    .short_decode_sel (short_decode_sel),
    .base_high        (win1_high_reg),
    .base_low_size    (win1_low_reg),
    .hit              (win1_hit)
  );

  io_window_match u_win2 (
    .addr             (io_addr),
    .short_decode_sel (short_decode_sel),
    .base_high        (win2_high_reg),
    .base_low_size    (win2_low_reg),
    .hit              (win2_hit)
  );

  // ==========================================================
  // fixed range decodes
  wire logic hd_addr;
  wire logic fd_addr;
  wire logic kbd_addr;
  wire logic dma_hi_addr;

  assign hd_addr = in_range(eff_addr, HD_LO, HD_HI)
                   || (eff_addr == HD_ALT);
  assign fd_addr = in_range(eff_addr, FD_LO, FD_HI);
  assign kbd_addr = (eff_addr == KBD_DATA) || (eff_addr == KBD_PORT)
                    || (eff_addr == KBD_CMD);
  assign dma_hi_addr = in_range(eff_addr, DMAH_LO, DMAH_HI)
                       && !eff_addr[0];

  // ==========================================================
  // trap hits, all gated by the global enable
  wire byte_t hit_a;
  wire byte_t hit_b;
  wire byte_t en_a;
  wire byte_t en_b;

  assign en_a = mgmt_enable ? mask_a_reg : 8'h00; // see [RULE_23]
  assign en_b = mgmt_enable ? mask_b_reg : 8'h00;

  assign hit_a[7] = 1'b0;
  assign hit_a[BIT_WIN2] = en_a[BIT_WIN2] && io_cycle
                           && win2_hit; // see [RULE_01]
  assign hit_a[BIT_WIN1] = en_a[BIT_WIN1] && io_cycle
                           && win1_hit; // see [RULE_02]
  // disk bits decode independently so a shared port sets both
  assign hit_a[BIT_HDISK] = en_a[BIT_HDISK] && io_cycle
                            && hd_addr; // see [RULE_03] [RULE_18]
  assign hit_a[BIT_FLOPPY] = en_a[BIT_FLOPPY] && io_cycle
                             && fd_addr; // see [RULE_04] [RULE_18]
  assign hit_a[BIT_PRINTER1] = en_a[BIT_PRINTER1] && io_cycle
      && in_range(eff_addr, LP1_LO, LP1_HI); // see [RULE_05]
  assign hit_a[BIT_SERIAL2] = en_a[BIT_SERIAL2] && io_cycle
      && in_range(eff_addr, SER2_LO, SER2_HI); // see [RULE_06]
  assign hit_a[BIT_SERIAL1] = en_a[BIT_SERIAL1] && io_cycle
      && in_range(eff_addr, SER1_LO, SER1_HI); // see [RULE_07]

  assign hit_b[BIT_KBD_RD] = en_b[BIT_KBD_RD] && io_rd
                             && kbd_addr; // see [RULE_08]
  assign hit_b[BIT_KBD_WR] = en_b[BIT_KBD_WR] && io_wr
                             && kbd_addr; // see [RULE_08]
  assign hit_b[BIT_CMOS] = en_b[BIT_CMOS] && io_wr
                           && (eff_addr == CMOS_IDX); // see [RULE_09]
  assign hit_b[BIT_DMA_HI] = en_b[BIT_DMA_HI] && io_wr
                             && dma_hi_addr; // see [RULE_10]
  assign hit_b[BIT_DMA_LO] = en_b[BIT_DMA_LO] && io_wr
      && in_range(eff_addr, DMAL_LO, DMAL_HI); // see [RULE_11]
  assign hit_b[BIT_IRQCTL_B] = en_b[BIT_IRQCTL_B] && io_wr
      && in_range(eff_addr, ICB_LO, ICB_HI); // see [RULE_12]
  assign hit_b[BIT_IRQCTL_A] = en_b[BIT_IRQCTL_A] && io_wr
      && in_range(eff_addr, ICA_LO, ICA_HI); // see [RULE_13]
  assign hit_b[BIT_TIMER] = en_b[BIT_TIMER] && io_wr
      && in_range(eff_addr, TMR_LO, TMR_HI); // see [RULE_14]

  // ==========================================================
  // status next values: a hit in the clearing read cycle survives
  wire byte_t status_a_next;
  wire byte_t status_b_next;
  wire logic  newly_set;
  wire logic  pending_next;
  wire byte_t read_mux;

  assign status_a_next = (rd_status_a ? RST_STATUS : status_a_reg)
                         | hit_a; // see [RULE_15] [RULE_16]
  assign status_b_next = (rd_status_b ? RST_STATUS : status_b_reg)
                         | hit_b; // see [RULE_15] [RULE_16]
  assign newly_set = |(hit_a & ~status_a_reg)
                     || |(hit_b & ~status_b_reg); // see [RULE_26]
  // timer flags are held and cleared by the timer block itself
  assign pending_next = |status_a_next || |status_b_next
                        || |timer_flags; // see [RULE_17]

  assign read_mux =
      is_reg(index_reg, OFF_MASK_A)    ? mask_a_reg    :
      is_reg(index_reg, OFF_MASK_B)    ? mask_b_reg    :
      is_reg(index_reg, OFF_STATUS_A)  ? status_a_reg  :
      is_reg(index_reg, OFF_STATUS_B)  ? status_b_reg  :
      is_reg(index_reg, OFF_WIN2_HIGH) ? win2_high_reg :
      is_reg(index_reg, OFF_WIN2_LOW)  ? win2_low_reg  :
      is_reg(index_reg, OFF_WIN1_HIGH) ? win1_high_reg :
      is_reg(index_reg, OFF_WIN1_LOW)  ? win1_low_reg  : 8'h00;

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      index_reg <= RST_INDEX;
    end else if (index_wr) begin
      index_reg <= io_wdata;
    end
  end

  // the undefined top bit of mask a is stored as written
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mask_a_reg <= RST_MASK;
      mask_b_reg <= RST_MASK;
    end else begin
      if (wr_mask_a) mask_a_reg <= io_wdata; // see [RULE_24]
      if (wr_mask_b) mask_b_reg <= io_wdata; // see [RULE_24]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      win2_high_reg <= RST_WIN;
      win2_low_reg  <= RST_WIN;
      win1_high_reg <= RST_WIN;
      win1_low_reg  <= RST_WIN;
    end else begin
      if (wr_win2_high) win2_high_reg <= io_wdata;
      if (wr_win2_low)  win2_low_reg  <= io_wdata;
      if (wr_win1_high) win1_high_reg <= io_wdata;
      if (wr_win1_low)  win1_low_reg  <= io_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status_a_reg <= RST_STATUS;
      status_b_reg <= RST_STATUS;
      irq_n_reg    <= 1'b1;
      pending_reg  <= 1'b0;
    end else begin
      status_a_reg <= status_a_next;
      status_b_reg <= status_b_next;
      irq_n_reg    <= ~newly_set; // see [RULE_26]
      pending_reg  <= pending_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_reg       <= 8'h00;
      rdata_valid_reg <= 1'b0;
    end else begin
      rdata_reg       <= rd_mapped ? read_mux : 8'h00;
      rdata_valid_reg <= rd_mapped;
    end
  end

  assign io_rdata         = rdata_reg;
  assign io_rdata_valid   = rdata_valid_reg;
  assign mgmt_irq_n       = irq_n_reg;
  assign any_trap_pending = pending_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_win2_trap: assert property ( // see [RULE_01]
    mgmt_enable && mask_a_reg[BIT_WIN2] && io_cycle && win2_hit
    |=> status_a_reg[BIT_WIN2])
    else $error("window 2 access not trapped");

  a_hdisk_alt: assert property ( // see [RULE_03]
    mgmt_enable && mask_a_reg[BIT_HDISK] && io_rd
    && eff_addr == HD_ALT |=> status_a_reg[BIT_HDISK])
    else $error("hard disk alternate port not trapped");

  a_kbd_read: assert property ( // see [RULE_08]
    mgmt_enable && mask_b_reg[BIT_KBD_RD] && !mask_b_reg[BIT_KBD_WR]
    && io_wr && !io_rd && kbd_addr && status_b_reg == 8'h00
    && !rd_status_b |=> status_b_reg == 8'h00)
    else $error("keyboard write trapped by read enable");

  a_cmos_read: assert property ( // see [RULE_09]
    io_rd && !io_wr && eff_addr == CMOS_IDX
    && !status_b_reg[BIT_CMOS] |=> !status_b_reg[BIT_CMOS])
    else $error("cmos index read was trapped");

  a_dma_odd: assert property ( // see [RULE_10]
    io_wr && eff_addr == 16'h00C1 && !status_b_reg[BIT_DMA_HI]
    |=> !status_b_reg[BIT_DMA_HI])
    else $error("odd dma high port was trapped");

  a_status_clear: assert property ( // see [RULE_16]
    rd_status_a && hit_a == 8'h00 |=> status_a_reg == 8'h00)
    else $error("status a not cleared by read");

  a_pending_sum: assert property ( // see [RULE_17]
    (|status_a_reg || |status_b_reg) |-> any_trap_pending)
    else $error("summary bit low with status set");

  a_global_off: assert property ( // see [RULE_23]
    !mgmt_enable [*2] |-> mgmt_irq_n)
    else $error("trap fired with management disabled");

  a_mask_lock: assert property ( // see [RULE_24]
    data_wr && mgmt_write_lock && !mgmt_active
    |=> $stable(mask_a_reg) && $stable(mask_b_reg))
    else $error("locked mask register was written");

  a_irq_pulse: assert property ( // see [RULE_26]
    newly_set |=> !mgmt_irq_n)
    else $error("interrupt pulse missing");

  a_irq_quiet: assert property ( // see [RULE_26]
    !newly_set |=> mgmt_irq_n)
    else $error("interrupt without new status bit");

  c_hdisk_trap: cover property (!mgmt_irq_n && status_a_reg[BIT_HDISK]);
  c_win1_trap:  cover property (status_a_reg[BIT_WIN1]);
  c_read_clear: cover property (rd_status_b && status_b_reg != 8'h00);
  c_lock_block: cover property (data_wr && !write_ok);

endmodule

// >>> core/io_break_pkg.sv
// constants and types of the management-mode i/o break decoder
// How it works
// [RULE_01] window 2 enable traps reads and writes inside
// [RULE_02] window 1 enable traps reads and writes inside
// [RULE_03] hard disk: ports 1F0h-1F7h and 3F6h
// [RULE_04] floppy: ports 3F0h-3F5h trapped
// [RULE_05] printer 1: ports 378h-37Ah trapped
// [RULE_06] serial 2: ports 2F8h-2FFh trapped
// [RULE_07] serial 1: ports 3F8h-3FFh trapped
// [RULE_08] keyboard 60h/61h/64h, separate read, write enables
// [RULE_09] cmos index 70h: writes only trapped
// [RULE_10] dma high: writes to even C0h-DEh
// [RULE_11] dma low: writes to 00h-0Fh
// [RULE_12] mask b bit 2: writes 20h-21h
// [RULE_13] mask b bit 1: writes A0h-A1h
// [RULE_14] interval timer: writes 40h-43h trapped
// [RULE_15] each firing trap sets its status bit
// [RULE_16] reading a status register clears it
// [RULE_17] pending summary follows status and timer flags
// [RULE_18] shared address sets both disk bits
// [RULE_19] size field selects 4/8/16/32 byte window
// [RULE_20] short decode ignores base bits 15-10
// [RULE_21] software loads window before enabling it
// [RULE_22] software preserves mask a top bit
// [RULE_23] nothing traps unless management enable set
// [RULE_24] lock makes masks read-only outside management mode
// [RULE_25] all decodes use 10 or 16 bits
// [RULE_26] newly set status pulses interrupt low
package io_break_pkg;

  typedef logic [15:0] io_addr_t;
  typedef logic [7:0]  byte_t;
  typedef logic [1:0]  win_size_t;

  // ==========================================================
  // configuration port pair
  localparam io_addr_t CFG_INDEX_PORT = 16'h00EC;
  localparam io_addr_t CFG_DATA_PORT  = 16'h00ED;

  // ==========================================================
  // register indices
  localparam byte_t OFF_MASK_A    = 8'h80;
  localparam byte_t OFF_MASK_B    = 8'h81;
  localparam byte_t OFF_STATUS_A  = 8'h82;
  localparam byte_t OFF_STATUS_B  = 8'h83;
  localparam byte_t OFF_WIN2_HIGH = 8'h84;
  localparam byte_t OFF_WIN2_LOW  = 8'h85;
  localparam byte_t OFF_WIN1_HIGH = 8'h86;
  localparam byte_t OFF_WIN1_LOW  = 8'h87;

  // ==========================================================
  // reset values
  localparam byte_t RST_MASK   = 8'h00;
  localparam byte_t RST_STATUS = 8'h00;
  localparam byte_t RST_WIN    = 8'h00;
  localparam byte_t RST_INDEX  = 8'h00;

  // ==========================================================
  // bit positions, mask / status a
  localparam int BIT_WIN2     = 6;
  localparam int BIT_WIN1     = 5;
  localparam int BIT_HDISK    = 4;
  localparam int BIT_FLOPPY   = 3;
  localparam int BIT_PRINTER1 = 2;
  localparam int BIT_SERIAL2  = 1;
  localparam int BIT_SERIAL1  = 0;
  // mask / status b
  localparam int BIT_KBD_RD   = 7;
  localparam int BIT_KBD_WR   = 6;
  localparam int BIT_CMOS     = 5;
  localparam int BIT_DMA_HI   = 4;
  localparam int BIT_DMA_LO   = 3;
  localparam int BIT_IRQCTL_B = 2;
  localparam int BIT_IRQCTL_A = 1;
  localparam int BIT_TIMER    = 0;
  // window low register: size field position
  localparam int BIT_SIZE_LSB = 0;

  // ==========================================================
  // window size codes
  localparam win_size_t SIZE_4  = 2'h0;
  localparam win_size_t SIZE_8  = 2'h1;
  localparam win_size_t SIZE_16 = 2'h2;
  localparam win_size_t SIZE_32 = 2'h3;

  // ==========================================================
  // fixed port ranges
  localparam io_addr_t HD_LO    = 16'h01F0;
  localparam io_addr_t HD_HI    = 16'h01F7;
  localparam io_addr_t HD_ALT   = 16'h03F6;
  localparam io_addr_t FD_LO    = 16'h03F0;
  localparam io_addr_t FD_HI    = 16'h03F5;
  localparam io_addr_t LP1_LO   = 16'h0378;
  localparam io_addr_t LP1_HI   = 16'h037A;
  localparam io_addr_t SER2_LO  = 16'h02F8;
  localparam io_addr_t SER2_HI  = 16'h02FF;
  localparam io_addr_t SER1_LO  = 16'h03F8;
  localparam io_addr_t SER1_HI  = 16'h03FF;
  localparam io_addr_t KBD_DATA = 16'h0060;
  localparam io_addr_t KBD_PORT = 16'h0061;
  localparam io_addr_t KBD_CMD  = 16'h0064;
  localparam io_addr_t CMOS_IDX = 16'h0070;
  localparam io_addr_t DMAH_LO  = 16'h00C0;
  localparam io_addr_t DMAH_HI  = 16'h00DE;
  localparam io_addr_t DMAL_LO  = 16'h0000;
  localparam io_addr_t DMAL_HI  = 16'h000F;
  localparam io_addr_t ICB_LO   = 16'h0020;
  localparam io_addr_t ICB_HI   = 16'h0021;
  localparam io_addr_t ICA_LO   = 16'h00A0;
  localparam io_addr_t ICA_HI   = 16'h00A1;
  localparam io_addr_t TMR_LO   = 16'h0040;
  localparam io_addr_t TMR_HI   = 16'h0043;

  localparam int TIMER_FLAGS = 5;

endpackage

// >>> core/io_window_match.sv
// programmable base-and-size i/o window comparator
`timescale 1ns/1ps
module io_window_match
  import io_break_pkg::*;
(
  input  wire io_break_pkg::io_addr_t addr,
  input  wire logic                   short_decode_sel,
  input  wire io_break_pkg::byte_t    base_high,
  input  wire io_break_pkg::byte_t    base_low_size,
  output logic                        hit
);

  // ==========================================================
  // compare mask
  function automatic io_addr_t care_mask(input win_size_t sz,
                                         input logic short_dec);
    io_addr_t m;
    m = 16'hFFFC;
    unique case (sz)
      SIZE_4:  m = 16'hFFFC;
      SIZE_8:  m = 16'hFFF8;
      SIZE_16: m = 16'hFFF0;
      SIZE_32: m = 16'hFFE0;
    endcase
    if (short_dec) begin
      m = m & 16'h03FF;
    end
    return m;
  endfunction

  wire win_size_t window_size;
  wire io_addr_t  base;
  wire io_addr_t  care;

  assign window_size = base_low_size[BIT_SIZE_LSB +: 2];
  assign base = {base_high, base_low_size[7:2], 2'h0};
  // size widens the window, short decode drops the upper base
  assign care = care_mask(window_size, short_decode_sel); // see [RULE_19] [RULE_20]
  assign hit  = ((addr ^ base) & care) == 16'h0000;

endmodule

// >>> verification/io_host_model.sv
// host processor model issuing single-byte i/o cycles
`timescale 1ns/1ps
module io_host_model
  import io_break_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic [7:0]        io_rdata,
  input  wire logic              io_rdata_valid,
  input  wire logic              mgmt_irq_n,
  output io_break_pkg::io_addr_t io_addr,
  output logic                   io_rd,
  output logic                   io_wr,
  output io_break_pkg::byte_t    io_wdata
);
  initial begin
    io_addr = 16'hFFFF;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'hFF;
  end

  // ==========================================================
  // bus cycle
  // address and data lines are inverted and the strobes dropped after the strobe so a stale value never passes
  task automatic access(input io_addr_t a, input logic rd, input byte_t d,
                        output logic [7:0] rdat, output logic rvld,
                        output logic irq_n);
    io_addr = a;
    io_rd = rd;
    io_wr = !rd;
    io_wdata = d;
    @(posedge sys_clk);
    #1;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
    rdat = io_rdata;
    rvld = io_rdata_valid;
    irq_n = mgmt_irq_n;
    @(posedge sys_clk);
    #1;
  endtask
endmodule

// >>> verification/tb.sv
// self-checking bench for the management-mode i/o break decoder
`timescale 1ns/1ps
module tb;
  import io_break_pkg::*;
  logic       sys_clk;
  logic       srst;
  logic       en;
  logic       lock;
  logic       act;
  logic       short_sel;
  logic [4:0] tflags;
  io_addr_t   io_addr;
  logic       io_rd;
  logic       io_wr;
  byte_t      io_wdata;
  logic [7:0] io_rdata;
  logic       io_rdata_valid;
  logic       mgmt_irq_n;
  logic       any_trap_pending;
  logic [7:0] r_dat;
  logic       r_vld;
  logic       r_irq;
  byte_t      m_a, m_b, w2h, w2l, w1h, w1l;
  int         bad_count;
  int         n_tests;
  io_addr_t   cor[30] = '{16'h01F0, 16'h01F7, 16'h03F6, 16'h03F0, 16'h03F5,
    16'h0378, 16'h037A, 16'h02F8, 16'h02FF, 16'h03F8, 16'h03FF, 16'h0060,
    16'h0061, 16'h0064, 16'h0070, 16'h00C0, 16'h00DE, 16'h0000, 16'h000F,
    16'h0020, 16'h00A1, 16'h0040, 16'h0043, 16'h5A40, 16'h5A48, 16'h5A50,
    16'h5A60, 16'h8120, 16'h8128, 16'h8140};

  smm_io_break_decoder smm_io_break_decoder_inst (
    .sys_clk(sys_clk), .srst(srst), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .mgmt_enable(en),
    .mgmt_write_lock(lock), .mgmt_active(act), .short_decode_sel(short_sel),
    .timer_flags(tflags), .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid), .mgmt_irq_n(mgmt_irq_n),
    .any_trap_pending(any_trap_pending));

  io_host_model io_host_model_inst (
    .sys_clk(sys_clk), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .mgmt_irq_n(mgmt_irq_n), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // helpers
  task automatic check(input logic ok, input string what);
    n_tests++;
    if (!ok) begin
      bad_count++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic acc(input io_addr_t a, input logic rd, input byte_t d);
    io_host_model_inst.access(a, rd, d, r_dat, r_vld, r_irq);
  endtask

  task automatic reg_rd(input byte_t i);
    acc(CFG_INDEX_PORT, 1'b0, i);
    acc(CFG_DATA_PORT, 1'b1, 8'h00);
  endtask

  task automatic reg_wr(input byte_t i, input byte_t d);
    acc(CFG_INDEX_PORT, 1'b0, i);
    acc(CFG_DATA_PORT, 1'b0, d);
    if (!lock || act) begin
      case (i)
        8'h80: m_a = d;
        8'h81: m_b = d;
        8'h84: w2h = d;
        8'h85: w2l = d;
        8'h86: w1h = d;
        8'h87: w1l = d;
        default: ;
      endcase
    end
  endtask

  task automatic readback();
    byte_t e[8];
    e = '{m_a, m_b, 8'h00, 8'h00, w2h, w2l, w1h, w1l};
    for (int i = 0; i < 8; i++) begin
      reg_rd(8'h80 + 8'(i));
      check(r_vld === 1'b1 && r_dat === e[i], "readback");
    end
  endtask

  function automatic logic in_r(io_addr_t a, io_addr_t lo, io_addr_t hi);
    return a >= lo && a <= hi;
  endfunction

  function automatic logic [15:0] exp_hits(io_addr_t a, logic rd);
    io_addr_t lim, ea, m2, m1;
    byte_t    sa, sb;
    logic     kb;
    lim = short_sel ? 16'h03FF : 16'hFFFF;
    ea = a & lim;
    m2 = ~((16'h0004 << w2l[1:0]) - 16'h0001) & lim;
    m1 = ~((16'h0004 << w1l[1:0]) - 16'h0001) & lim;
    kb = ea == 16'h0060 || ea == 16'h0061 || ea == 16'h0064;
    sa[7] = 1'b0;
    sa[6] = (ea & m2) == ({w2h, w2l[7:2], 2'b00} & m2);
    sa[5] = (ea & m1) == ({w1h, w1l[7:2], 2'b00} & m1);
    sa[4] = in_r(ea, 16'h01F0, 16'h01F7) || ea == 16'h03F6;
    sa[3] = in_r(ea, 16'h03F0, 16'h03F5);
    sa[2] = in_r(ea, 16'h0378, 16'h037A);
    sa[1] = in_r(ea, 16'h02F8, 16'h02FF);
    sa[0] = in_r(ea, 16'h03F8, 16'h03FF);
    sb[7] = rd && kb;
    sb[6] = !rd && kb;
    sb[5] = !rd && ea == 16'h0070;
    sb[4] = !rd && in_r(ea, 16'h00C0, 16'h00DE) && !ea[0];
    sb[3] = !rd && ea <= 16'h000F;
    sb[2] = !rd && in_r(ea, 16'h0020, 16'h0021);
    sb[1] = !rd && in_r(ea, 16'h00A0, 16'h00A1);
    sb[0] = !rd && in_r(ea, 16'h0040, 16'h0043);
    return en ? {sb & m_b, sa & m_a} : 16'h0000;
  endfunction

  // windows go in before the enables that use them
  task automatic reconfig();
    en = ($urandom % 8) != 0;
    lock = 1'($urandom);
    act = 1'($urandom);
    short_sel = 1'($urandom);
    reg_wr(OFF_WIN2_HIGH, 8'h5A);
    reg_wr(OFF_WIN2_LOW, 8'h40 | 8'($urandom % 4));
    reg_wr(OFF_WIN1_HIGH, 8'h81);
    reg_wr(OFF_WIN1_LOW, 8'h20 | 8'($urandom % 4));
    reg_wr(OFF_MASK_A, {m_a[7], 7'($urandom)});
    reg_wr(OFF_MASK_B, 8'($urandom));
    acc(CFG_INDEX_PORT, 1'b0, OFF_STATUS_A);
    acc(CFG_DATA_PORT, 1'b0, 8'hFF);
    readback();
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] e;
    io_addr_t    a;
    logic        rd;
    void'($urandom(16080));
    bad_count = 0;
    n_tests = 0;
    srst = 1'b1;
    en = 1'b1;
    lock = 1'b0;
    act = 1'b0;
    short_sel = 1'b0;
    tflags = 5'h00;
    {m_a, m_b, w2h, w2l, w1h, w1l} = '0;
    repeat (12) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    @(posedge sys_clk);
    #1;
    readback();
    reg_rd(8'h88);
    check(r_vld === 1'b0, "unmapped index answered");
    tflags = 5'h04;
    repeat (2) @(posedge sys_clk);
    #1;
    check(any_trap_pending === 1'b1, "timer flag missing");
    tflags = 5'h00;
    repeat (2) @(posedge sys_clk);
    #1;
    check(any_trap_pending === 1'b0, "summary stuck");
    for (int k = 0; k < 320; k++) begin
      if (k % 8 == 0) reconfig();
      a = cor[$urandom % 30] + 16'($urandom % 3) - 16'h0001;
      if ($urandom % 2) a[15:10] = 6'($urandom);
      rd = 1'($urandom);
      e = exp_hits(a, rd);
      acc(a, rd, 8'($urandom));
      check(r_irq === (e == 16'h0000), "irq pulse wrong");
      check(any_trap_pending === (e != 16'h0000), "summary");
      acc(a, rd, 8'h5A);
      check(r_irq === 1'b1, "irq on already set bit");
      reg_rd(OFF_STATUS_A);
      check(r_vld === 1'b1 && r_dat === e[7:0], "status a");
      if (e[7:0] != 8'h00) begin
        reg_rd(OFF_STATUS_A);
        check(r_dat === 8'h00, "status a not cleared");
      end
      reg_rd(OFF_STATUS_B);
      check(r_vld === 1'b1 && r_dat === e[15:8], "status b");
      check(any_trap_pending === 1'b0, "summary stuck");
    end
    print_verdict();
  end

  initial begin
    #1000000;
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
